/* core/sbrg_pkg.sv */
// Constants for the serial bit-rate generator and serial/timer control.
// Assumes a single 10 MHz clock and a plain strobe register port.
package sbrg_pkg;
	// ----------------------------------------
	// Clock
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_RELOAD = 4'h1;
	localparam logic [3:0] OFS_MODE = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'hff;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTRL_TWO_WIRE_LSB = 4;
	localparam int CTRL_HOST_SWITCH = 3;
	localparam int CTRL_MP_ENABLE = 2;
	localparam int CTRL_TIMER_LSB = 0;

	// ----------------------------------------
	// Mode register fields
	// ----------------------------------------
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_MP_FORMAT = 2;
	localparam int MODE_SYNC = 3;
	localparam int MODE_DOUBLE = 4;
	localparam int MODE_PERIPH_HALF = 5;
	localparam logic [7:0] MODE_MASK = 8'h3f;

	// ----------------------------------------
	// Serial clock structure
	// ----------------------------------------
	localparam logic [3:0] ASYNC_OVERSAMPLE_LAST = 4'hf;
endpackage : sbrg_pkg

/* core/sbrg_prescaler.sv */
// Prescaler: one-cycle ticks at the selected fraction of the clock.
// Assumes sel and dbl come straight from software registers.
module sbrg_prescaler (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] sel,
	input wire logic dbl,
	input wire logic periphHalf,
	output logic tick
);
	// ----------------------------------------
	// Divide mask
	// ----------------------------------------
	function automatic logic [7:0] sbrg_mask(input logic [1:0] s, input logic d);
		logic [7:0] m;
		m = 8'h00;
		case (s)
			2'h1: m = d ? 8'h07 : 8'h03;
			2'h2: m = d ? 8'h1f : 8'h0f;
			2'h3: m = d ? 8'h7f : 8'h3f;
			default: m = 8'h00;
		endcase
		return m;
	endfunction : sbrg_mask

	logic [7:0] cnt;
	logic periphEn;
	logic [7:0] mask;

	assign mask = sbrg_mask(sel, dbl);

	// Peripheral clock runs at full or half rate
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			periphEn <= 1'b0;
		end else begin
			periphEn <= periphHalf ? ~periphEn : 1'b1;
		end
	end

	// Free counter; a select change only shifts the phase of the next tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= 8'h00;
		end else if (periphEn) begin
			cnt <= cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick <= 1'b0;
		end else if (sel == 2'h0) begin
			tick <= 1'b1;
		end else begin
			tick <= periphEn && ((cnt & mask) == mask);
		end
	end

	AST_PRE_DIV4: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && sel == 2'h1 && !dbl && !periphHalf && $past(sel) == 2'h1 && !$past(dbl)) ##1
		(sel == 2'h1 && !dbl && !periphHalf)[*4] |-> tick && !$past(tick))
		else $error("Prescaler quarter rate wrong");
	AST_PRE_DIV8: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && sel == 2'h1 && dbl && !periphHalf && $past(sel) == 2'h1 && $past(dbl)) ##1
		(sel == 2'h1 && dbl && !periphHalf)[*8] |-> tick && !$past(tick))
		else $error("Prescaler eighth rate wrong");
	AST_PRE_SYS: assert property (@(posedge clk) disable iff (!rst_n)
		sel == 2'h0 ##1 sel == 2'h0 |-> tick)
		else $error("Undivided clock not selected");
endmodule : sbrg_prescaler

/* core/sbrg_bit_rate_generator.sv */
// Serial bit-rate generator and serial/timer control register.
// Assumes the serial channels take the clock enables and mode outputs.
//
// Functional notes
// - Async rate is F/(64*2^(2n-1)*(N+1))
// - Sync rate is F/(8*2^(2n-1)*(N+1))
// - Reload value accepts 0 through 255
// - Select 0..3 gives clock /1,/4,/16,/64
// - Doubled select gives /1,/8,/32,/128
// - n zero uses system, else peripheral clock
// - Control register is 8-bit read/write
// - Reset clears control register
// - Bit 2 gates multiprocessor on both channels
// - Enable low keeps multiprocessor off
// - Enable high lets format bit select it (code: only while the sync bit is low)
// - Bits 7..4 go to two-wire unit
// - Bit 3 goes to host input switch
// - Bits 1..0 go to timer clock select
// - Async serial clock is sixteen times bit
//
// Added by the designer: the register addresses and the plain strobed port.
module sbrg_bit_rate_generator (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	output logic [3:0] twoWireCtrl,
	output logic hostInputSwitch,
	output logic [1:0] timerClockSelect,
	output logic multiprocActive0,
	output logic multiprocActive1,
	output logic syncMode,
	output logic serialClkEn,
	output logic bitTick
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] serialTimerControl;
	logic [7:0] bitRateReload;
	logic [7:0] modeReg;
	logic [7:0] activeReload;
	logic [7:0] divCount;
	logic halfPhase;
	logic [3:0] edgeCount;
	logic preTick;
	logic wrap;
	logic clkEnNext;
	logic next_bitTick;
	logic [7:0] next_rdData;

	function automatic logic sbrg_hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction : sbrg_hit

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	sbrg_prescaler uPre (
		.clk(clk),
		.rst_n(rst_n),
		.sel(modeReg[sbrg_pkg::MODE_SEL_LSB +: 2]),
		.dbl(modeReg[sbrg_pkg::MODE_DOUBLE]),
		.periphHalf(modeReg[sbrg_pkg::MODE_PERIPH_HALF]),
		.tick(preTick)
	);

	// ----------------------------------------
	// Software writes
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serialTimerControl <= sbrg_pkg::CTRL_RESET;
		end else if (wrStb && sbrg_hit(addr, sbrg_pkg::OFS_CTRL)) begin
			serialTimerControl <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bitRateReload <= sbrg_pkg::RELOAD_RESET;
		end else if (wrStb && sbrg_hit(addr, sbrg_pkg::OFS_RELOAD)) begin
			bitRateReload <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			modeReg <= sbrg_pkg::MODE_RESET;
		end else if (wrStb && sbrg_hit(addr, sbrg_pkg::OFS_MODE)) begin
			modeReg <= wrData & sbrg_pkg::MODE_MASK;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_comb begin
		next_rdData = 8'h00;
		if (rdStb) begin
			case (addr)
				sbrg_pkg::OFS_CTRL: next_rdData = serialTimerControl;
				sbrg_pkg::OFS_RELOAD: next_rdData = bitRateReload;
				sbrg_pkg::OFS_MODE: next_rdData = modeReg;
				sbrg_pkg::OFS_STATUS: next_rdData = divCount;
				default: next_rdData = 8'h00;
			endcase
		end
	end

	// Data stands one cycle only, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdData <= 8'h00;
		end else begin
			rdData <= next_rdData;
		end
	end

	// ----------------------------------------
	// Pass-through control outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			twoWireCtrl <= 4'h0;
			hostInputSwitch <= 1'b0;
			timerClockSelect <= 2'h0;
		end else begin
			twoWireCtrl <= serialTimerControl[sbrg_pkg::CTRL_TWO_WIRE_LSB +: 4];
			hostInputSwitch <= serialTimerControl[sbrg_pkg::CTRL_HOST_SWITCH];
			timerClockSelect <= serialTimerControl[sbrg_pkg::CTRL_TIMER_LSB +: 2];
		end
	end

	// One enable serves both channels; each channel's own format bit is
	// shared here since only one mode register sits in this block
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			multiprocActive0 <= 1'b0;
			multiprocActive1 <= 1'b0;
			syncMode <= 1'b0;
		end else begin
			multiprocActive0 <= serialTimerControl[sbrg_pkg::CTRL_MP_ENABLE]
				&& modeReg[sbrg_pkg::MODE_MP_FORMAT] && !modeReg[sbrg_pkg::MODE_SYNC];
			multiprocActive1 <= serialTimerControl[sbrg_pkg::CTRL_MP_ENABLE]
				&& modeReg[sbrg_pkg::MODE_MP_FORMAT] && !modeReg[sbrg_pkg::MODE_SYNC];
			syncMode <= modeReg[sbrg_pkg::MODE_SYNC];
		end
	end

	// ----------------------------------------
	// Reload divider
	// ----------------------------------------
	assign wrap = preTick && (divCount == activeReload);

	// A reload written mid-count waits for the wrap, so no short period occurs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divCount <= 8'h00;
			activeReload <= sbrg_pkg::RELOAD_RESET;
		end else if (wrap) begin
			divCount <= 8'h00;
			activeReload <= bitRateReload;
		end else if (preTick) begin
			divCount <= divCount + 8'h01;
		end
	end

	// Two wraps per serial clock edge: the 64 and 8 bases share a /2 stage
	assign clkEnNext = wrap && halfPhase;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			halfPhase <= 1'b0;
		end else if (wrap) begin
			halfPhase <= ~halfPhase;
		end
	end

	// Async: 16 edges per bit; sync: 2 edges per bit.
	// N=0 at n=0 in sync leaves no slack for back-to-back bytes.
	always_comb begin
		next_bitTick = 1'b0;
		if (clkEnNext) begin
			if (modeReg[sbrg_pkg::MODE_SYNC]) begin
				next_bitTick = edgeCount[0];
			end else begin
				next_bitTick = edgeCount == sbrg_pkg::ASYNC_OVERSAMPLE_LAST;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			edgeCount <= 4'h0;
		end else if (clkEnNext) begin
			edgeCount <= edgeCount + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serialClkEn <= 1'b0;
			bitTick <= 1'b0;
		end else begin
			serialClkEn <= clkEnNext;
			bitTick <= next_bitTick;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_CTRL_RESET: assert property (@(posedge clk)
		!rst_n |=> serialTimerControl == 8'h00 && twoWireCtrl == 4'h0)
		else $error("Control register not cleared by reset");
	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wrStb && addr == sbrg_pkg::OFS_CTRL ##1 rdStb && addr == sbrg_pkg::OFS_CTRL
		|=> rdData == $past(wrData, 2))
		else $error("Control readback differs from write");
	AST_TWO_WIRE: assert property (@(posedge clk) disable iff (!rst_n)
		wrStb && addr == sbrg_pkg::OFS_CTRL |=> ##1 twoWireCtrl == $past(wrData[7:4], 2))
		else $error("Two-wire control not passed");
	AST_HOST_TIMER: assert property (@(posedge clk) disable iff (!rst_n)
		wrStb && addr == sbrg_pkg::OFS_CTRL |=> ##1
		hostInputSwitch == $past(wrData[3], 2) && timerClockSelect == $past(wrData[1:0], 2))
		else $error("Host switch or timer select not passed");
	AST_MP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		!serialTimerControl[2] |=> !multiprocActive0 && !multiprocActive1)
		else $error("Multiprocessor active while disabled");
	AST_MP_ON: assert property (@(posedge clk) disable iff (!rst_n)
		serialTimerControl[2] && modeReg[2] && !modeReg[3] |=> multiprocActive0 && multiprocActive1)
		else $error("Multiprocessor format not selected");
	AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		wrap |=> divCount == 8'h00 && activeReload == $past(bitRateReload))
		else $error("Divider wrap or reload wrong");
	AST_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		divCount <= activeReload)
		else $error("Divider passed its reload value");
	AST_FASTEST: assert property (@(posedge clk) disable iff (!rst_n)
		serialClkEn && modeReg[1:0] == 2'h0 && activeReload == 8'h00 && bitRateReload == 8'h00
		##1 modeReg[1:0] == 2'h0 |=> serialClkEn)
		else $error("Fastest serial clock period is not two cycles");
	AST_BIT_ON_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
		bitTick |-> serialClkEn ##1 !serialClkEn)
		else $error("Bit tick off a serial clock edge");
	AST_SYNC_BIT: assert property (@(posedge clk) disable iff (!rst_n)
		clkEnNext && modeReg[3] |=> bitTick == $past(edgeCount[0]))
		else $error("Sync bit tick wrong");

	COV_ASYNC_BIT: cover property (@(posedge clk) disable iff (!rst_n) bitTick && !syncMode);
	COV_SYNC_BIT: cover property (@(posedge clk) disable iff (!rst_n) bitTick && syncMode);
	COV_FULL_RELOAD: cover property (@(posedge clk) disable iff (!rst_n) wrap && activeReload == 8'hff);
	COV_MP: cover property (@(posedge clk) disable iff (!rst_n) multiprocActive0);
endmodule : sbrg_bit_rate_generator

/* sim/sbrg_serial_partner.sv */
// Partner model: serial channel logic that consumes the rate enables.
// Assumes one-cycle enable pulses launched on the rising clock edge.
module sbrg_serial_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serialClkEn,
	input wire logic bitTick,
	output int enCount,
	output int enPeriod,
	output int enPerBit,
	output int strayTicks
);
	timeunit 1ns;
	timeprecision 1ns;
	int sinceEn;
	int enSinceBit;
	// ----------------------------------------
	// Pulse bookkeeping
	// ----------------------------------------
	// Only counts pulses; never asks for back-to-back sync transfers
	always @(posedge clk) begin
		if (!rst_n) begin
			enCount <= 0;
			enPeriod <= 0;
			enPerBit <= 0;
			strayTicks <= 0;
			sinceEn <= 0;
			enSinceBit <= 0;
		end else begin
			sinceEn <= sinceEn + 1;
			if (serialClkEn === 1'b1) begin
				enCount <= enCount + 1;
				enPeriod <= sinceEn + 1;
				sinceEn <= 0;
				enSinceBit <= enSinceBit + 1;
			end
			// The coinciding enable belongs to the bit that ends here
			if (bitTick === 1'b1) begin
				enPerBit <= enSinceBit + 1;
				enSinceBit <= 0;
				if (serialClkEn !== 1'b1) begin
					strayTicks <= strayTicks + 1;
				end
			end
		end
	end
endmodule : sbrg_serial_partner

/* sim/sbrg_bit_rate_generator_tb_top.sv */
// Testbench: register port, pass-through outputs and serial clock rates.
// Assumes the partner model measures the enable pulses.
module sbrg_bit_rate_generator_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	wire logic [7:0] rdData;
	wire logic [3:0] twoWireCtrl;
	wire logic hostInputSwitch;
	wire logic [1:0] timerClockSelect;
	wire logic multiprocActive0;
	wire logic multiprocActive1;
	wire logic syncMode;
	wire logic serialClkEn;
	wire logic bitTick;
	int enCount, enPeriod, enPerBit, strayTicks;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 65758;
	int nv;
	logic [7:0] v, r, mv;

	always #50 clk = ~clk;

	sbrg_bit_rate_generator u_sbrg_bit_rate_generator (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.twoWireCtrl(twoWireCtrl), .hostInputSwitch(hostInputSwitch),
		.timerClockSelect(timerClockSelect), .multiprocActive0(multiprocActive0),
		.multiprocActive1(multiprocActive1), .syncMode(syncMode),
		.serialClkEn(serialClkEn), .bitTick(bitTick));

	sbrg_serial_partner u_sbrg_serial_partner (.clk(clk), .rst_n(rst_n),
		.serialClkEn(serialClkEn), .bitTick(bitTick), .enCount(enCount),
		.enPeriod(enPeriod), .enPerBit(enPerBit), .strayTicks(strayTicks));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wrReg

	// Read data stand only in the cycle after the strobe
	task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		@(negedge clk);
		d = rdData;
	endtask : rdReg

	task automatic waitEn(input int k);
		int target;
		target = enCount + k;
		for (int i = 0; i < 20000 && enCount < target; i++) @(posedge clk);
		@(negedge clk);
	endtask : waitEn

	// Divider ratio worked out from the select tables; peripheral halving only when sel is not 0
	function automatic int expPeriod(input int sel, input int dbl, input int half, input int n);
		int div;
		div = (sel == 0) ? 1 : (4 ** sel) * (dbl != 0 ? 2 : 1);
		if (sel != 0 && half != 0) div = div * 2;
		return 2 * div * (n + 1);
	endfunction : expPeriod

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			n_errors++;
			$display("watchdog expired");
			wrap_up();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("outputs", 0, {twoWireCtrl, hostInputSwitch, timerClockSelect, syncMode});
		rdReg(sbrg_pkg::OFS_CTRL, r);
		chk("ctrl reset", 8'h00, r);
		rdReg(sbrg_pkg::OFS_RELOAD, r);
		chk("reload reset", sbrg_pkg::RELOAD_RESET, r);
		rdReg(4'h9, r);
		chk("unmapped", 8'h00, r);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'hff : 8'($random(seed));
			wrReg(sbrg_pkg::OFS_CTRL, v);
			wrReg(4'h9, ~v);
			rdReg(sbrg_pkg::OFS_CTRL, r);
			chk("ctrl", v, r);
			chk("twoWireCtrl", v[7:4], twoWireCtrl);
			chk("hostInputSwitch", v[3], hostInputSwitch);
			chk("timerClockSelect", v[1:0], timerClockSelect);
		end
		// Write then read with no gap between the strobes
		@(posedge clk);
		addr <= sbrg_pkg::OFS_CTRL;
		wrData <= 8'h5a;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		@(negedge clk);
		chk("ctrl back to back", 8'h5a, rdData);
		for (int m = 0; m < 8; m++) begin
			wrReg(sbrg_pkg::OFS_CTRL, 8'(m & 1) << sbrg_pkg::CTRL_MP_ENABLE);
			mv = (8'((m >> 1) & 1) << sbrg_pkg::MODE_MP_FORMAT) | (8'(m >> 2) << sbrg_pkg::MODE_SYNC);
			wrReg(sbrg_pkg::OFS_MODE, mv);
			repeat (3) @(posedge clk);
			@(negedge clk);
			chk("mp0", m == 3, multiprocActive0);
			chk("mp1", m == 3, multiprocActive1);
			chk("syncMode", m >> 2, syncMode);
		end
		for (int k = 0; k < 16; k++) begin
			nv = (k == 0) ? 255 : (k == 4) ? 0 : ($random(seed) & 3);
			mv = 8'(k & 3) | (8'(k % 3 == 0) << sbrg_pkg::MODE_SYNC);
			mv = mv | (8'((k >> 2) & 1) << sbrg_pkg::MODE_DOUBLE);
			mv = mv | (8'(k >> 3) << sbrg_pkg::MODE_PERIPH_HALF);
			wrReg(sbrg_pkg::OFS_RELOAD, 8'(nv));
			wrReg(sbrg_pkg::OFS_MODE, mv);
			rdReg(sbrg_pkg::OFS_RELOAD, r);
			chk("reload", nv, r);
			rdReg(sbrg_pkg::OFS_MODE, r);
			chk("mode", mv, r);
			waitEn(3);
			chk("period", expPeriod(k & 3, (k >> 2) & 1, k >> 3, nv), enPeriod);
		end
		wrReg(sbrg_pkg::OFS_RELOAD, 8'h00);
		wrReg(sbrg_pkg::OFS_MODE, 8'h00);
		waitEn(40);
		chk("async enables per bit", 16, enPerBit);
		wrReg(sbrg_pkg::OFS_MODE, 8'h01 << sbrg_pkg::MODE_SYNC);
		waitEn(40);
		chk("sync enables per bit", 2, enPerBit);
		chk("stray bit ticks", 0, strayTicks);
		wrap_up();
	end
endmodule : sbrg_bit_rate_generator_tb_top
